// ==== core/rx_backend_defines.svh ====
// register offsets, field positions, reset values and timing counts for the receiver back end
// Functional notes
// [RL1] enabled and locked stabilizer regenerates the falling edge for 50% duty
// [RL2] stabilizer loop stays idle while sample clock is below 40 MHz
// [RL3] after a clock rate change relock takes 1.5 to 5 us; user waits
// [RL4] while unlocked, internal timing follows the incoming clock duty cycle directly
// [RL5] power-down when register bit set or power-down pin high
// [RL6] sample-data drivers go high impedance during power-down
// [RL7] pin low wakes device; wake-up time grows with time spent powered down
// [RL8] standby keeps reference powered, rest off, wakes faster than power-down
// [RL9] sync input passes an internal synchronizer before aligning the divider
// [RL10] host drives sync as CMOS retimed to the sample clock
// [RL11] samples reach outputs nine sample clocks later, after rising edge
// [RL12] data strobe high carries channels A and C, low carries B and D
// [RL13] output coding selectable as offset binary or twos complement
// [RL14] mid, negative and positive full scale codes as tabled; overrange clamps
// [RL15] requantizer enabled attenuates path by 0.6 dB
// [RL16] requantizer enable per channel, from registers or mode-select pin
// [RL17] band mode 000 is 22 percent band, 57 tuning words
// [RL18] band mode 001 is 33 percent band, 34 tuning words
// [RL19] 6-bit tuning word at 0x3E, band mode bits at 0x3C
// [RL20] mode-select low enables requantizer, high gives plain 11-bit output
// [RL21] mode-select pulled up, so undriven pin disables requantizer
// [RL22] control bit 4 makes channel ignore the mode-select pin
// [RL23] clock divider ratios 1 through 8
// [RL24] with bit 1 of 0x3A set, each valid sync resets the divider
// [RL25] channel ignoring the pin takes enable solely from its register bit
// [RL26] out-of-range tuning words clamp to the mode's largest word
`ifndef RX_BACKEND_DEFINES_SVH
`define RX_BACKEND_DEFINES_SVH

// register offsets
`define ADDR_CLK_DIV 8'h0B
`define ADDR_PWR_CTL 8'h08
`define ADDR_DCS_CTL 8'h09
`define ADDR_FMT_CTL 8'h14
`define ADDR_STATUS 8'h0F
`define ADDR_SYNC_CTL 8'h3A
`define ADDR_REQ_CTL 8'h3C
`define ADDR_REQ_TUNE 8'h3E

// field positions
`define REQ_CTL_EN_BIT 0
`define REQ_CTL_MODE_LSB 1
`define REQ_CTL_IGNORE_BIT 4
`define SYNC_CTL_DIV_BIT 1
`define PWR_CTL_PD_BIT 0
`define PWR_CTL_SB_BIT 1
`define DCS_CTL_EN_BIT 0
`define FMT_CTL_TWOS_BIT 0

// reset values
`define RST_REQ_CTL 8'h00
`define RST_REQ_TUNE 8'h00
`define RST_SYNC_CTL 8'h00
`define RST_PWR_CTL 8'h00
`define RST_DCS_CTL 8'h01
`define RST_FMT_CTL 8'h00
`define RST_CLK_DIV 8'h00

// band modes and tuning limits
`define BAND_22 3'h0
`define BAND_33 3'h1
`define TUNE_MAX_22 6'h38
`define TUNE_MAX_33 6'h21

// data path
`define PIPE_LAT 9
`define ATTEN_GAIN 32'sh0000_3BBA
`define ATTEN_SHIFT 14
`define SHORT_MODE_MASK 16'hFFE0

// timing
`define CLK_MHZ 10
`define RELOCK_MIN_NS 1500
`define RELOCK_MAX_NS 5000
`define RELOCK_CYC ((`RELOCK_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== core/rx_backend_pkg.sv ====
// types shared by the receiver back end
package rx_backend_pkg;

    typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_STANDBY, PWR_WAKE} pwr_state_t;

    // everything the back end keeps between clock edges
    typedef struct packed {
        logic [3:0][7:0] req_ctl;
        logic [3:0][7:0] req_tune;
        logic [7:0] sync_ctl;
        logic [7:0] pwr_ctl;
        logic [7:0] dcs_ctl;
        logic [7:0] fmt_ctl;
        logic [7:0] clk_div;
        logic [7:0] rdata;
        logic [2:0] div_cnt;
        logic sample_tick;
        logic sync_s1;
        logic sync_s2;
        logic sync_s3;
        logic [8:0][3:0][15:0] pipe;
        logic [1:0][15:0] ddr_word;
        logic strobe;
        logic [7:0] lock_cnt;
        logic locked;
        logic [15:0] pd_time;
        logic [15:0] wake_cnt;
        pwr_state_t pwr;
    } state_t;

    // per-channel status towards the analog side
    typedef struct packed {
        logic [3:0] req_enable;
        logic [3:0][2:0] band_mode;
        logic [3:0][5:0] band_tuning_word;
    } chan_status_t;

endpackage

// ==== core/quad_receiver_digital_backend.sv ====
// digital back end of the four-channel receiver: registers, clocking, power and output data
`timescale 1ns/1ps
`default_nettype none
`include "rx_backend_defines.svh"

module quad_receiver_digital_backend #(
    parameter int WAKE_MAX_CYC = 1000,
    parameter int STANDBY_WAKE_CYC = 4
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [3:0] reg_chan_mask_in,
    output logic [7:0] reg_rdata_out,
    // pins
    input wire logic power_down_request_in,
    input wire logic mode_select_in,
    input wire logic sync_in,
    // clock monitor
    input wire logic clk_rate_low_in,
    input wire logic clk_rate_change_in,
    // converter samples, signed, one per channel
    input wire logic [3:0][16:0] adc_sample_in,
    // sample data link
    output logic [1:0][15:0] data_pair_out,
    output logic data_oe_n_out,
    output logic output_data_strobe_out,
    // clocking, power and per-channel status
    output logic sample_tick_out,
    output logic duty_cycle_stabilizer_locked_out,
    output logic duty_regen_out,
    output logic reference_powered_out,
    output logic core_powered_out,
    output logic ready_out,
    output rx_backend_pkg::chan_status_t chan_status_out
);

    generate
        if (WAKE_MAX_CYC < 1 || WAKE_MAX_CYC > 65535 || STANDBY_WAKE_CYC < 1 ||
            STANDBY_WAKE_CYC > WAKE_MAX_CYC) begin : g_bad_param
            $error("wake counts out of range");
        end
    endgenerate

    localparam logic [15:0] WAKE_MAX = 16'(WAKE_MAX_CYC);
    localparam logic [15:0] WAKE_SB = 16'(STANDBY_WAKE_CYC);
    localparam logic [7:0] RELOCK = 8'(`RELOCK_CYC);

    rx_backend_pkg::state_t s_q;
    rx_backend_pkg::state_t s_d;
    rx_backend_pkg::chan_status_t chan_st;
    logic [3:0][15:0] coded;
    logic [3:0] wr_sel;
    logic pd_req;
    logic sync_edge;

    // per-channel requantizer enable, band limits and output coding
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            logic ignore_pin;
            logic [2:0] mode;
            logic [5:0] tw_raw;
            logic [5:0] tw_max;
            logic signed [16:0] clamped;
            logic signed [31:0] scaled;
            logic [15:0] word;

            assign ignore_pin = s_q.req_ctl[ch][`REQ_CTL_IGNORE_BIT];
            assign mode = s_q.req_ctl[ch][`REQ_CTL_MODE_LSB +: 3];
            assign tw_raw = s_q.req_tune[ch][5:0]; // [RL19]
            // 22 percent band allows words 0..56, 33 percent band 0..33
            assign tw_max = (mode == `BAND_33) ? `TUNE_MAX_33 : `TUNE_MAX_22; // [RL17] [RL18]
            // larger words would push the band past the Nyquist edge, so clamp
            assign chan_st.band_tuning_word[ch] = (tw_raw > tw_max) ? tw_max : tw_raw; // [RL26]
            // undefined mode codes fall back to the 22 percent band
            assign chan_st.band_mode[ch] = (mode == `BAND_33) ? `BAND_33 : `BAND_22;
            // pin low enables; pin high (also the pulled-up idle level) disables
            assign chan_st.req_enable[ch] = ignore_pin ?
                s_q.req_ctl[ch][`REQ_CTL_EN_BIT] : // [RL22] [RL25]
                !mode_select_in; // [RL16] [RL20] [RL21]

            // clamp beyond full scale to the end codes
            always_comb begin
                if ($signed(adc_sample_in[ch]) > 17'sh0_7FFF) begin
                    clamped = 17'sh0_7FFF; // [RL14]
                end else if ($signed(adc_sample_in[ch]) < -17'sh0_8000) begin
                    clamped = -17'sh0_8000; // [RL14]
                end else begin
                    clamped = $signed(adc_sample_in[ch]);
                end
            end

            // 0.6 dB loss through the requantizer, plain 11-bit word otherwise
            assign scaled = (32'(clamped) * `ATTEN_GAIN) >>> `ATTEN_SHIFT; // [RL15]
            assign word = chan_st.req_enable[ch] ? scaled[15:0] :
                (clamped[15:0] & `SHORT_MODE_MASK); // [RL20]
            // offset binary is the twos complement word with its sign bit flipped
            assign coded[ch] = s_q.fmt_ctl[`FMT_CTL_TWOS_BIT] ? word :
                {!word[15], word[14:0]}; // [RL13] [RL14]
        end
    endgenerate

    assign pd_req = s_q.pwr_ctl[`PWR_CTL_PD_BIT] || power_down_request_in; // [RL5]
    // only the second and third synchronizer stages feed the edge detector
    assign sync_edge = s_q.sync_s2 && !s_q.sync_s3; // [RL9] [RL10]

    // channel index mask picks which channels a per-channel write reaches
    always_comb begin
        wr_sel = '0;
        if (reg_wr_en_in) begin
            wr_sel = reg_chan_mask_in;
        end
    end

    // next state
    always_comb begin
        s_d = s_q;

        // register writes
        if (reg_wr_en_in) begin
            if (reg_addr_in == `ADDR_SYNC_CTL) begin
                s_d.sync_ctl = reg_wdata_in;
            end else if (reg_addr_in == `ADDR_PWR_CTL) begin
                s_d.pwr_ctl = reg_wdata_in;
            end else if (reg_addr_in == `ADDR_DCS_CTL) begin
                s_d.dcs_ctl = reg_wdata_in;
            end else if (reg_addr_in == `ADDR_FMT_CTL) begin
                s_d.fmt_ctl = reg_wdata_in;
            end else if (reg_addr_in == `ADDR_CLK_DIV) begin
                s_d.clk_div = {5'h00, reg_wdata_in[2:0]}; // [RL23]
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (wr_sel[i] && reg_addr_in == `ADDR_REQ_CTL) begin
                s_d.req_ctl[i] = {3'h0, reg_wdata_in[4:0]}; // [RL19]
            end else if (wr_sel[i] && reg_addr_in == `ADDR_REQ_TUNE) begin
                s_d.req_tune[i] = {2'h0, reg_wdata_in[5:0]}; // [RL19]
            end
        end

        // register reads, per-channel ones from the lowest selected channel
        if (reg_rd_en_in) begin
            s_d.rdata = 8'h00;
            if (reg_addr_in == `ADDR_SYNC_CTL) begin
                s_d.rdata = s_q.sync_ctl;
            end else if (reg_addr_in == `ADDR_PWR_CTL) begin
                s_d.rdata = s_q.pwr_ctl;
            end else if (reg_addr_in == `ADDR_DCS_CTL) begin
                s_d.rdata = s_q.dcs_ctl;
            end else if (reg_addr_in == `ADDR_FMT_CTL) begin
                s_d.rdata = s_q.fmt_ctl;
            end else if (reg_addr_in == `ADDR_CLK_DIV) begin
                s_d.rdata = s_q.clk_div;
            end else if (reg_addr_in == `ADDR_STATUS) begin
                s_d.rdata = {4'h0, s_q.pwr, ready_out, s_q.locked};
            end else if (reg_addr_in == `ADDR_REQ_CTL || reg_addr_in == `ADDR_REQ_TUNE) begin
                for (int i = 3; i >= 0; i--) begin
                    if (reg_chan_mask_in[i]) begin
                        s_d.rdata = (reg_addr_in == `ADDR_REQ_CTL) ?
                            s_q.req_ctl[i] : s_q.req_tune[i];
                    end
                end
            end
        end

        // sync synchronizer and divider; a sync restarts the count at zero
        s_d.sync_s1 = sync_in;
        s_d.sync_s2 = s_q.sync_s1;
        s_d.sync_s3 = s_q.sync_s2;
        s_d.sample_tick = 1'b0;
        if (sync_edge && s_q.sync_ctl[`SYNC_CTL_DIV_BIT]) begin
            s_d.div_cnt = 3'h0; // [RL24]
        end else if (s_q.div_cnt >= s_q.clk_div[2:0]) begin
            s_d.div_cnt = 3'h0; // [RL23]
            s_d.sample_tick = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 3'h1;
        end

        // nine-sample pipeline, advancing on each sample tick
        if (s_q.sample_tick) begin
            s_d.pipe[0] = coded; // [RL11]
            for (int k = 1; k < `PIPE_LAT; k++) begin
                s_d.pipe[k] = s_q.pipe[k - 1]; // [RL11]
            end
        end

        // double-rate strobe: high phase carries A and C, low phase B and D
        s_d.strobe = !s_q.strobe;
        if (s_d.strobe) begin
            s_d.ddr_word[0] = s_q.pipe[`PIPE_LAT - 1][0]; // [RL12]
            s_d.ddr_word[1] = s_q.pipe[`PIPE_LAT - 1][2]; // [RL12]
        end else begin
            s_d.ddr_word[0] = s_q.pipe[`PIPE_LAT - 1][1]; // [RL12]
            s_d.ddr_word[1] = s_q.pipe[`PIPE_LAT - 1][3]; // [RL12]
        end

        // stabilizer relock timer; idle below 40 MHz or when disabled
        if (!s_q.dcs_ctl[`DCS_CTL_EN_BIT] || clk_rate_low_in) begin
            s_d.locked = 1'b0; // [RL2]
            s_d.lock_cnt = 8'h00;
        end else if (clk_rate_change_in) begin
            s_d.locked = 1'b0; // [RL3]
            s_d.lock_cnt = 8'h00;
        end else if (!s_q.locked) begin
            s_d.lock_cnt = s_q.lock_cnt + 8'h01;
            s_d.locked = (s_q.lock_cnt + 8'h01) >= RELOCK; // [RL3]
        end

        // power sequencing
        case (s_q.pwr)
            rx_backend_pkg::PWR_RUN: begin
                s_d.pd_time = 16'h0000;
                if (pd_req) begin
                    s_d.pwr = rx_backend_pkg::PWR_DOWN; // [RL5]
                end else if (s_q.pwr_ctl[`PWR_CTL_SB_BIT]) begin
                    s_d.pwr = rx_backend_pkg::PWR_STANDBY; // [RL8]
                end
            end
            rx_backend_pkg::PWR_DOWN: begin
                // capacitors drain longer the longer we sit here
                if (s_q.pd_time < WAKE_MAX) begin
                    s_d.pd_time = s_q.pd_time + 16'h0001; // [RL7]
                end
                if (!pd_req) begin
                    s_d.pwr = rx_backend_pkg::PWR_WAKE; // [RL7]
                    s_d.wake_cnt = s_q.pd_time; // [RL7]
                end
            end
            rx_backend_pkg::PWR_STANDBY: begin
                if (pd_req) begin
                    s_d.pwr = rx_backend_pkg::PWR_DOWN;
                end else if (!s_q.pwr_ctl[`PWR_CTL_SB_BIT]) begin
                    s_d.pwr = rx_backend_pkg::PWR_WAKE;
                    s_d.wake_cnt = WAKE_SB; // [RL8]
                end
            end
            default: begin
                if (pd_req) begin
                    s_d.pwr = rx_backend_pkg::PWR_DOWN;
                end else if (s_q.wake_cnt == 16'h0000) begin
                    s_d.pwr = rx_backend_pkg::PWR_RUN;
                end else begin
                    s_d.wake_cnt = s_q.wake_cnt - 16'h0001;
                end
            end
        endcase
    end

    // single state register
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.req_ctl <= {4{`RST_REQ_CTL}};
            s_q.req_tune <= {4{`RST_REQ_TUNE}};
            s_q.sync_ctl <= `RST_SYNC_CTL;
            s_q.pwr_ctl <= `RST_PWR_CTL;
            s_q.dcs_ctl <= `RST_DCS_CTL;
            s_q.fmt_ctl <= `RST_FMT_CTL;
            s_q.clk_div <= `RST_CLK_DIV;
            s_q.pwr <= rx_backend_pkg::PWR_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign reg_rdata_out = s_q.rdata;
    assign data_pair_out = s_q.ddr_word;
    assign output_data_strobe_out = s_q.strobe;
    // drivers float while powered down, in standby or waking
    assign data_oe_n_out = (s_q.pwr != rx_backend_pkg::PWR_RUN); // [RL6]
    assign sample_tick_out = s_q.sample_tick;
    assign duty_cycle_stabilizer_locked_out = s_q.locked;
    // regenerated 50% edge only when locked, raw input duty otherwise
    assign duty_regen_out = s_q.locked && s_q.dcs_ctl[`DCS_CTL_EN_BIT]; // [RL1] [RL4]
    assign reference_powered_out = (s_q.pwr != rx_backend_pkg::PWR_DOWN); // [RL8]
    assign core_powered_out = (s_q.pwr == rx_backend_pkg::PWR_RUN) ||
        (s_q.pwr == rx_backend_pkg::PWR_WAKE);
    assign ready_out = (s_q.pwr == rx_backend_pkg::PWR_RUN);
    assign chan_status_out = chan_st;

endmodule
`default_nettype wire

// ==== dv/backend_properties.sv ====
// concurrent checks on the receiver back end ports
`timescale 1ns/1ps
`default_nettype none
module backend_properties #(
    parameter int WAKE_MAX_CYC = 1000,
    parameter int STANDBY_WAKE_CYC = 4
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // watched inputs
    input wire logic reg_rd_en_in,
    input wire logic power_down_request_in,
    input wire logic clk_rate_low_in,
    input wire logic clk_rate_change_in,
    // watched outputs
    input wire logic [7:0] reg_rdata_out,
    input wire logic data_oe_n_out,
    input wire logic output_data_strobe_out,
    input wire logic duty_cycle_stabilizer_locked_out,
    input wire logic duty_regen_out,
    input wire logic reference_powered_out,
    input wire logic core_powered_out,
    input wire logic ready_out
);
    // wake bound capped so the range stays checkable for big parameters
    localparam int WAKE_BOUND = (WAKE_MAX_CYC < 990) ? WAKE_MAX_CYC + 8 : 1000;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // 13 unlocked cycles kept as margin under the 1.5 us minimum
    sequence s_unlocked;
        !duty_cycle_stabilizer_locked_out [*7] ##1 !duty_cycle_stabilizer_locked_out [*6];
    endsequence
    sequence s_wake;
        !ready_out ##[1:WAKE_BOUND] ready_out;
    endsequence
    a_strobe_toggles: assert property (!$past(rst_in) |-> $changed(output_data_strobe_out))
        else $error("data strobe did not toggle");
    a_pin_powers_down: assert property (power_down_request_in |=> data_oe_n_out && !ready_out)
        else $error("power-down pin ignored");
    a_down_state_off: assert property (!reference_powered_out |-> data_oe_n_out && !core_powered_out)
        else $error("outputs driven with reference off");
    a_oe_follows_run: assert property (ready_out != data_oe_n_out)
        else $error("output enable disagrees with run state");
    a_regen_needs_lock: assert property (duty_regen_out |-> duty_cycle_stabilizer_locked_out)
        else $error("edge regenerated while unlocked");
    a_slow_clk_unlocks: assert property (clk_rate_low_in [*2] |-> !duty_cycle_stabilizer_locked_out)
        else $error("stabilizer locked on slow clock");
    a_relock_window: assert property (clk_rate_change_in && !clk_rate_low_in |=> s_unlocked ##[1:37] duty_cycle_stabilizer_locked_out)
        else $error("relock outside its window");
    a_pin_wakes: assert property ($fell(power_down_request_in) |-> s_wake)
        else $error("no wake after power-down pin fell");
    a_read_data_holds: assert property (!reg_rd_en_in |=> $stable(reg_rdata_out))
        else $error("read data changed without a read");
endmodule
bind quad_receiver_digital_backend backend_properties #(
    .WAKE_MAX_CYC(WAKE_MAX_CYC),
    .STANDBY_WAKE_CYC(STANDBY_WAKE_CYC)
) u_backend_properties (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .reg_rd_en_in(reg_rd_en_in),
    .power_down_request_in(power_down_request_in),
    .clk_rate_low_in(clk_rate_low_in),
    .clk_rate_change_in(clk_rate_change_in),
    .reg_rdata_out(reg_rdata_out),
    .data_oe_n_out(data_oe_n_out),
    .output_data_strobe_out(output_data_strobe_out),
    .duty_cycle_stabilizer_locked_out(duty_cycle_stabilizer_locked_out),
    .duty_regen_out(duty_regen_out),
    .reference_powered_out(reference_powered_out),
    .core_powered_out(core_powered_out),
    .ready_out(ready_out)
);
`default_nettype wire

// ==== dv/ddr_capture_model.sv ====
// capture register model on the double-data-rate sample link
`timescale 1ns/1ps
`default_nettype none
module ddr_capture_model (
    // link from the back end
    input wire logic clk_in,
    input wire logic [1:0][15:0] data_pair_in,
    input wire logic oe_n_in,
    input wire logic strobe_in,
    // captured words, index 0 is channel A
    output logic [3:0][15:0] chan_out
);
    logic [1:0][15:0] last;
    logic [1:0][15:0] seen;
    // released lanes show the inverse of the last driven word, not a stale copy
    assign seen = oe_n_in ? ~last : data_pair_in;
    // strobe high carries A and C, low carries B and D
    always @(posedge clk_in) begin
        if (!oe_n_in) begin
            last <= data_pair_in;
        end
        if (strobe_in) begin
            chan_out[0] <= seen[0];
            chan_out[2] <= seen[1];
        end else begin
            chan_out[1] <= seen[0];
            chan_out[3] <= seen[1];
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the receiver back end
`timescale 1ns/1ps
`default_nettype none
`include "rx_backend_defines.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [3:0] mask = 4'h1;
    logic pd_pin = 1'b0;
    logic mode_pin = 1'b1;
    logic sync = 1'b0;
    logic rate_low = 1'b0;
    logic rate_chg = 1'b0;
    logic [3:0][16:0] samples = {17'h0_03E8, 17'h0_FFFF, 17'h1_0000, 17'h0_0000};
    logic [7:0] rdata, got;
    logic [1:0][15:0] pair;
    logic [3:0][15:0] cap;
    logic oe_n, strobe, tick, locked, regen, ref_on, core_on, ready;
    rx_backend_pkg::chan_status_t status;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int n, m;
    quad_receiver_digital_backend #(.WAKE_MAX_CYC(16), .STANDBY_WAKE_CYC(4)) u_quad_receiver_digital_backend (
        .core_clk_in(clk), .rst_in(rst), .reg_wr_en_in(wr), .reg_rd_en_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_chan_mask_in(mask), .reg_rdata_out(rdata),
        .power_down_request_in(pd_pin), .mode_select_in(mode_pin), .sync_in(sync),
        .clk_rate_low_in(rate_low), .clk_rate_change_in(rate_chg), .adc_sample_in(samples),
        .data_pair_out(pair), .data_oe_n_out(oe_n), .output_data_strobe_out(strobe),
        .sample_tick_out(tick), .duty_cycle_stabilizer_locked_out(locked), .duty_regen_out(regen),
        .reference_powered_out(ref_on), .core_powered_out(core_on), .ready_out(ready),
        .chan_status_out(status)
    );
    ddr_capture_model u_ddr_capture_model (
        .clk_in(clk), .data_pair_in(pair), .oe_n_in(oe_n), .strobe_in(strobe), .chan_out(cap)
    );
    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            results();
        end
    end
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // one register access on a falling edge: write when w is high, else read into got
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] m);
        @(negedge clk);
        {wr, rd, addr, wdata, mask} = {w, !w, a, d, m};
        @(negedge clk);
        {wr, rd} = 2'b00;
        got = rdata;
    endtask
    // expected word: clamp, requantize or cut to 11 bits, then format
    function automatic logic [15:0] code(input logic [16:0] x, input logic req, input logic twos);
        logic signed [31:0] v;
        v = 32'($signed(x));
        if (v > 32'sh0000_7FFF) v = 32'sh0000_7FFF;
        if (v < -32'sh0000_8000) v = -32'sh0000_8000;
        if (req) v = (v * `ATTEN_GAIN) >>> `ATTEN_SHIFT;
        else v = v & 32'sh0000_FFE0;
        return {v[15] ^ !twos, v[14:0]};
    endfunction
    task automatic lanes(input logic [3:0] req, input logic twos);
        for (int i = 0; i < 4; i++) begin
            chk("lane", cap[i], code(samples[i], req[i], twos));
        end
    endtask
    task automatic wait_ready(output int k);
        k = 0;
        while (ready !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        chk("ready", {15'h0000, ready}, 16'h0001);
    endtask
    task automatic gap(output int k);
        k = 1;
        cyc(1);
        while (tick !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
    endtask
    // main sequence
    initial begin
        cyc(12);
        rst = 1'b0;
        bus(1'b1, `ADDR_REQ_CTL, 8'hFF, 4'h1);
        bus(1'b0, `ADDR_REQ_CTL, 8'h00, 4'h1);
        chk("ctl", {8'h00, got}, 16'h001F);
        bus(1'b1, `ADDR_REQ_CTL, 8'h00, 4'h1);
        bus(1'b1, `ADDR_REQ_TUNE, 8'hFF, 4'hC);
        bus(1'b0, `ADDR_REQ_TUNE, 8'h00, 4'h4);
        chk("tune", {8'h00, got}, 16'h003F);
        bus(1'b0, 8'h55, 8'h00, 4'h1);
        chk("unmapped", {8'h00, got}, 16'h0000);
        bus(1'b1, `ADDR_REQ_CTL, 8'h11, 4'h2);
        bus(1'b1, `ADDR_REQ_CTL, 8'h12, 4'h4);
        bus(1'b1, `ADDR_REQ_CTL, 8'h10, 4'h8);
        chk("mode c", {13'h0000, status.band_mode[2]}, 16'h0001);
        chk("word c", {10'h000, status.band_tuning_word[2]}, 16'h0021);
        chk("mode d", {13'h0000, status.band_mode[3]}, 16'h0000);
        chk("word d", {10'h000, status.band_tuning_word[3]}, 16'h0038);
        chk("enable pin high", {12'h000, status.req_enable}, 16'h0002);
        mode_pin = 1'b0;
        cyc(1);
        chk("enable pin low", {12'h000, status.req_enable}, 16'h0003);
        $display("test registers done");
        mode_pin = 1'b1;
        cyc(20);
        lanes(4'h2, 1'b0);
        bus(1'b1, `ADDR_FMT_CTL, 8'h01, 4'h1);
        mode_pin = 1'b0;
        cyc(20);
        lanes(4'h3, 1'b1);
        samples[0] = 17'h0_4000;
        n = 0;
        while (cap[0] !== code(samples[0], 1'b1, 1'b1) && n < 40) begin
            cyc(1);
            n++;
        end
        chk("latency", 16'(n >= 9 && n <= 13), 16'h0001);
        $display("test data link done");
        pd_pin = 1'b1;
        cyc(3);
        chk("pin down", {15'h0000, oe_n}, 16'h0001);
        pd_pin = 1'b0;
        wait_ready(n);
        pd_pin = 1'b1;
        cyc(12);
        pd_pin = 1'b0;
        wait_ready(m);
        chk("wake grows", 16'(m > n), 16'h0001);
        bus(1'b1, `ADDR_PWR_CTL, 8'h01, 4'h1);
        bus(1'b0, `ADDR_STATUS, 8'h00, 4'h1);
        chk("state", {14'h0000, got[3:2]}, 16'h0001);
        chk("ref and oe", {14'h0000, ref_on, oe_n}, 16'h0001);
        bus(1'b1, `ADDR_PWR_CTL, 8'h00, 4'h1);
        wait_ready(n);
        bus(1'b1, `ADDR_PWR_CTL, 8'h02, 4'h1);
        cyc(1);
        chk("standby", {14'h0000, ref_on, core_on}, 16'h0002);
        bus(1'b1, `ADDR_PWR_CTL, 8'h00, 4'h1);
        wait_ready(n);
        $display("test power done");
        rate_chg = 1'b1;
        cyc(1);
        rate_chg = 1'b0;
        cyc(3);
        chk("relocking", {14'h0000, locked, regen}, 16'h0000);
        cyc(60);
        chk("locked", {14'h0000, locked, regen}, 16'h0003);
        bus(1'b1, `ADDR_DCS_CTL, 8'h00, 4'h1);
        cyc(1);
        chk("stabilizer off", {14'h0000, locked, regen}, 16'h0000);
        bus(1'b1, `ADDR_DCS_CTL, 8'h01, 4'h1);
        rate_low = 1'b1;
        cyc(3);
        chk("slow clock", {14'h0000, locked, regen}, 16'h0000);
        rate_low = 1'b0;
        $display("test stabilizer done");
        bus(1'b1, `ADDR_CLK_DIV, 8'h07, 4'h1);
        gap(n);
        gap(n);
        chk("period", 16'(n), 16'h0008);
        cyc(5);
        sync = 1'b1; // driven on a falling core clock edge, five cycles after a sample tick
        gap(n);
        sync = 1'b0;
        chk("sync ignored", 16'(n), 16'h0003);
        bus(1'b1, `ADDR_SYNC_CTL, 8'h02, 4'h1);
        gap(n);
        cyc(5);
        sync = 1'b1;
        gap(n);
        sync = 1'b0;
        chk("sync aligns", 16'(n > 4), 16'h0001);
        $display("test divider done");
        results();
    end
endmodule
`default_nettype wire
